// File: design/svo_cfg.svh
// Purpose: constants of the serial offset receiver
// Assumes: 100 MHz core clock
// Notes: definitions only
`ifndef SVO_CFG_SVH
`define SVO_CFG_SVH

// ****************
// packet layout
// ****************
`define SVO_PKT_BITS 4'h8
`define SVO_PKT_CHANNEL_BIT_BIT 7
`define SVO_PKT_SIGN_BIT 6
`define SVO_PKT_MAG_HI 5
`define SVO_PKT_MAG_LO 1

// ****************
// mode setting bits
// ****************
`define SVO_MODE_LSB_BIT 2
`define SVO_MODE_FSHIFT_BIT 3
`define SVO_MODE_BCAST_BIT 4

// ****************
// step sizes, mV
// ****************
`define SVO_LSB_SMALL_MV 11'sh005
`define SVO_LSB_LARGE_MV 11'sh00A

// ****************
// timing
// ****************
`define SVO_CLK_MHZ 100
`define SVO_GAP_NS 4000
`define SVO_GAP_CYC ((`SVO_GAP_NS * `SVO_CLK_MHZ) / 1000)

// ****************
// target selects
// ****************
`define SVO_SEL_NOM 2'h0
`define SVO_SEL_HIGH 2'h1
`define SVO_SEL_LOW 2'h2

`endif

// File: design/svo_pkg.sv
// Purpose: shared types of the serial offset receiver
// Assumes: nothing
// Notes: constants live in svo_cfg.svh
package svo_pkg;
  typedef enum logic [0:0] {
    SVO_IDLE,
    SVO_FRAME
  } svo_state_type;

  // two's complement offset code, -31..+31 steps
  typedef logic signed [5:0] svo_code_type;

  // offset in mV, +-310 fits
  typedef logic signed [10:0] svo_mv_type;
endpackage

// File: design/svo_sync.sv
// Purpose: two-stage synchroniser for a group of pins
// Assumes: inputs are asynchronous to clk_i
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module svo_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_reg <= RST;
      q_o <= RST;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// File: design/svo_fifo.sv
// Purpose: packet buffer between receiver and offset apply
// Assumes: single clock
// Notes: full and empty are exact, storage in flip-flops
`timescale 1ns/100ps
module svo_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_reg != FULL);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
    end else if (push & ~pop) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else if (pop & ~push) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// File: design/svo_top.sv
// Purpose: write-only serial offset receiver, two channels
// Assumes: serial clock well below clk_i / 4 (oversampled)
// Notes: error flag pin is open drain, low when flagged
`timescale 1ns/100ps
`include "svo_cfg.svh"

module svo_top #(
  parameter int VW = 16,
  parameter int FIFO_DEPTH = 16,
  parameter int GAP_CYC = `SVO_GAP_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sck_i,
  input wire logic chip_select_n_i,
  input wire logic sdi_i,
  output logic xfer_error_flag_o,
  output logic xfer_error_flag_oe_o,
  input wire logic [1:0][7:0] pwm_mode_setting_i,
  input wire logic [1:0] rail_off_i,
  input wire logic device_reset_cmd_i,
  input wire logic restore_cmd_i,
  input wire logic [1:0] servo_en_i,
  input wire logic [1:0][1:0] margin_sel_i,
  input wire logic [1:0][VW-1:0] nominal_vout_target_i,
  input wire logic [1:0][VW-1:0] margin_high_i,
  input wire logic [1:0][VW-1:0] margin_low_i,
  input wire logic [1:0][VW-1:0] ov_fault_i,
  input wire logic [1:0][VW-1:0] uv_fault_i,
  input wire logic [1:0][VW-1:0] ov_warn_i,
  input wire logic [1:0][VW-1:0] uv_warn_i,
  output logic [1:0][VW-1:0] nominal_adj_o,
  output logic [1:0][VW-1:0] margin_high_adj_o,
  output logic [1:0][VW-1:0] margin_low_adj_o,
  output logic [1:0][VW-1:0] servo_target_o,
  output logic [1:0][VW-1:0] ov_fault_adj_o,
  output logic [1:0][VW-1:0] uv_fault_adj_o,
  output logic [1:0][VW-1:0] ov_warn_o,
  output logic [1:0][VW-1:0] uv_warn_o,
  output svo_pkg::svo_code_type [1:0] offset_readback_o,
  output svo_pkg::svo_mv_type [1:0] offset_mv_o
);
  import svo_pkg::*;

  // counter sized from the gap so a longer gap never wraps the load
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam logic [GW-1:0] GAP_LOAD = GW'(GAP_CYC - 1);
  // ****************
  // functions
  // ****************

  // sign-magnitude packet to two's complement code
  function automatic svo_code_type pkt_code(
    input logic [7:0] pkt
  );
    svo_code_type mag;
    mag = {1'b0, pkt[`SVO_PKT_MAG_HI:`SVO_PKT_MAG_LO]};
    pkt_code = pkt[`SVO_PKT_SIGN_BIT] ? -mag : mag;
  endfunction

  // target plus signed offset, floored at zero, capped at full scale
  function automatic logic [VW-1:0] add_off(
    input logic [VW-1:0] tgt,
    input svo_mv_type off
  );
    logic signed [VW+1:0] sum;
    sum = $signed({2'b00, tgt}) + (VW + 2)'(off);
    if (sum < 0) begin
      add_off = '0;
    end else if (sum[VW]) begin
      add_off = '1;
    end else begin
      add_off = sum[VW-1:0];
    end
  endfunction

  // ****************
  // pin synchronisers
  // ****************

  logic sck_s;
  logic csn_s;
  logic sdi_s;

  svo_sync #(
    .W(3),
    .RST(3'h2)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({sck_i, chip_select_n_i, sdi_i}),
    .q_o({sck_s, csn_s, sdi_s})
  );

  // ****************
  // edge detection
  // ****************

  logic sck_d_reg;
  logic csn_d_reg;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sck_d_reg <= 1'b0;
      csn_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      csn_d_reg <= csn_s;
    end
  end

  assign sck_fall = sck_d_reg & ~sck_s;
  assign cs_fall = csn_d_reg & ~csn_s;
  assign cs_rise = ~csn_d_reg & csn_s;

  // ****************
  // packet receiver
  // ****************

  // rate limit: serial clock must stay above 2 clk_i per half period
  svo_state_type state_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic pkt_good;
  logic fifo_in_ready;
  logic pkt_valid_reg;
  logic [7:0] pkt_data_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= SVO_IDLE;
    end else begin
      case (state_reg)
        SVO_IDLE: begin
          if (cs_fall) begin
            state_reg <= SVO_FRAME;
          end
        end
        SVO_FRAME: begin
          if (cs_rise) begin
            state_reg <= SVO_IDLE;
          end
        end
        default: begin
          state_reg <= SVO_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i | cs_fall) begin
      cnt_reg <= 4'h0;
    end else if (state_reg == SVO_FRAME && sck_fall &&
                 cnt_reg <= `SVO_PKT_BITS) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shift_reg <= 8'h00;
    end else if (state_reg == SVO_FRAME && sck_fall &&
                 cnt_reg < `SVO_PKT_BITS) begin
      shift_reg <= {shift_reg[6:0], sdi_s};
    end
  end

  assign pkt_good = (cnt_reg == `SVO_PKT_BITS) & (^shift_reg);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pkt_valid_reg <= 1'b0;
      pkt_data_reg <= 8'h00;
    end else begin
      pkt_valid_reg <= (state_reg == SVO_FRAME) & cs_rise &
                       pkt_good & fifo_in_ready;
      pkt_data_reg <= shift_reg;
    end
  end

  // ****************
  // error flag pin
  // ****************

  // a full buffer also flags, so the host sees the drop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      xfer_error_flag_oe_o <= 1'b0;
    end else if (cs_fall) begin
      xfer_error_flag_oe_o <= 1'b0;
    end else if (state_reg == SVO_FRAME && cs_rise &&
                 !(pkt_good && fifo_in_ready)) begin
      xfer_error_flag_oe_o <= 1'b1;
    end
  end

  // open drain, only ever pulls low
  always_ff @(posedge clk_i) begin
    xfer_error_flag_o <= 1'b0;
  end

  // ****************
  // packet buffer
  // ****************

  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic apply;
  logic [GW-1:0] gap_reg;

  svo_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(pkt_valid_reg),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pkt_data_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  assign fifo_out_ready = (gap_reg == '0);
  assign apply = fifo_out_valid & fifo_out_ready;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gap_reg <= '0;
    end else if (apply) begin
      gap_reg <= GAP_LOAD;
    end else if (gap_reg != '0) begin
      gap_reg <= gap_reg - 1'b1;
    end
  end

  // ****************
  // channel offsets
  // ****************

  logic bcast;
  logic clear_all;

  assign bcast = pwm_mode_setting_i[0][`SVO_MODE_BCAST_BIT] |
                 pwm_mode_setting_i[1][`SVO_MODE_BCAST_BIT];
  assign clear_all = device_reset_cmd_i | restore_cmd_i;

  for (genvar c = 0; c < 2; c++) begin : g_channel_bit
    svo_code_type code_reg;
    svo_mv_type mv;
    logic hit;
    logic [VW-1:0] nom_a;
    logic [VW-1:0] mhi_a;
    logic [VW-1:0] mlo_a;
    logic [VW-1:0] sel_raw;
    logic [VW-1:0] sel_adj;

    assign hit = apply &
      (bcast | (fifo_out_data[`SVO_PKT_CHANNEL_BIT_BIT] == 1'(c)));

    // clear wins over a packet landing in the same cycle
    always_ff @(posedge clk_i) begin
      if (srst_i | clear_all | rail_off_i[c]) begin
        code_reg <= '0;
      end else if (hit) begin
        code_reg <= pkt_code(fifo_out_data);
      end
    end

    assign mv = svo_mv_type'(code_reg) *
      (pwm_mode_setting_i[c][`SVO_MODE_LSB_BIT] ?
       `SVO_LSB_LARGE_MV : `SVO_LSB_SMALL_MV);

    assign nom_a = add_off(nominal_vout_target_i[c], mv);
    assign mhi_a = add_off(margin_high_i[c], mv);
    assign mlo_a = add_off(margin_low_i[c], mv);

    always_comb begin
      case (margin_sel_i[c])
        `SVO_SEL_HIGH: begin
          sel_raw = margin_high_i[c];
          sel_adj = mhi_a;
        end
        `SVO_SEL_LOW: begin
          sel_raw = margin_low_i[c];
          sel_adj = mlo_a;
        end
        default: begin
          sel_raw = nominal_vout_target_i[c];
          sel_adj = nom_a;
        end
      endcase
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        nominal_adj_o[c] <= '0;
        margin_high_adj_o[c] <= '0;
        margin_low_adj_o[c] <= '0;
        servo_target_o[c] <= '0;
      end else begin
        nominal_adj_o[c] <= nom_a;
        margin_high_adj_o[c] <= mhi_a;
        margin_low_adj_o[c] <= mlo_a;
        servo_target_o[c] <= servo_en_i[c] ? sel_adj : sel_raw;
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        ov_fault_adj_o[c] <= '0;
        uv_fault_adj_o[c] <= '0;
      end else if (pwm_mode_setting_i[c][`SVO_MODE_FSHIFT_BIT]) begin
        ov_fault_adj_o[c] <= add_off(ov_fault_i[c], mv);
        uv_fault_adj_o[c] <= add_off(uv_fault_i[c], mv);
      end else begin
        ov_fault_adj_o[c] <= ov_fault_i[c];
        uv_fault_adj_o[c] <= uv_fault_i[c];
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        ov_warn_o[c] <= '0;
        uv_warn_o[c] <= '0;
      end else begin
        ov_warn_o[c] <= ov_warn_i[c];
        uv_warn_o[c] <= uv_warn_i[c];
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        offset_readback_o[c] <= '0;
        offset_mv_o[c] <= '0;
      end else begin
        offset_readback_o[c] <= code_reg;
        offset_mv_o[c] <= mv;
      end
    end
  end
endmodule

// File: testbench/svo_top_properties.sv
// Purpose: port checks of the serial offset receiver
// Assumes: channel 0 targets kept clear of saturation
// Notes: bound into svo_top, one clock domain
`timescale 1ns/100ps
module svo_top_properties #(
  parameter int VW = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic chip_select_n_i,
  input wire logic xfer_error_flag_o,
  input wire logic xfer_error_flag_oe_o,
  input wire logic [1:0][7:0] pwm_mode_setting_i,
  input wire logic [1:0] rail_off_i,
  input wire logic device_reset_cmd_i,
  input wire logic restore_cmd_i,
  input wire logic [1:0] servo_en_i,
  input wire logic [1:0][1:0] margin_sel_i,
  input wire logic [1:0][VW-1:0] nominal_vout_target_i,
  input wire logic [1:0][VW-1:0] margin_high_i,
  input wire logic [1:0][VW-1:0] ov_fault_i,
  input wire logic [1:0][VW-1:0] ov_warn_i,
  input wire logic [1:0][VW-1:0] nominal_adj_o,
  input wire logic [1:0][VW-1:0] servo_target_o,
  input wire logic [1:0][VW-1:0] ov_fault_adj_o,
  input wire logic [1:0][VW-1:0] ov_warn_o,
  input wire svo_pkg::svo_code_type [1:0] offset_readback_o,
  input wire svo_pkg::svo_mv_type [1:0] offset_mv_o
);
  import svo_pkg::*;
  // ****************
  // helpers
  // ****************
  logic csn_q_reg;
  logic [3:0] rise_cnt_reg, fall_cnt_reg, run_cnt_reg;
  // past values are junk until the pipeline refills after reset
  wire run_ok = run_cnt_reg == 4'hF;
  wire svo_mv_type mv0 = offset_mv_o[0];
  always_ff @(posedge clk_i) begin
    if (srst_i) csn_q_reg <= 1'b1;
    else csn_q_reg <= chip_select_n_i;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) rise_cnt_reg <= 4'hF;
    else if (chip_select_n_i && !csn_q_reg) rise_cnt_reg <= 4'h0;
    else if (rise_cnt_reg != 4'hF) rise_cnt_reg <= rise_cnt_reg + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) fall_cnt_reg <= 4'hF;
    else if (!chip_select_n_i && csn_q_reg) fall_cnt_reg <= 4'h0;
    else if (fall_cnt_reg != 4'hF) fall_cnt_reg <= fall_cnt_reg + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) run_cnt_reg <= 4'h0;
    else if (!run_ok) run_cnt_reg <= run_cnt_reg + 4'h1;
  end
  function automatic logic [VW-1:0] addo(input logic [VW-1:0] t,
                                         input svo_mv_type o);
    return t + VW'(o);
  endfunction
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_flag_nodata: assert property (
    xfer_error_flag_o == 1'b0) else $error("flag pin drives high");
  chk_flag_cause: assert property (
    $rose(xfer_error_flag_oe_o) |-> chip_select_n_i && rise_cnt_reg <= 4'h6)
    else $error("flag raised away from deselect");
  chk_flag_hold: assert property (
    $fell(xfer_error_flag_oe_o) |-> fall_cnt_reg <= 4'h6)
    else $error("flag released without select");
  chk_step_scale: assert property (
    (run_ok && $stable(mv0) && $stable(pwm_mode_setting_i[0]))[*3] |->
    mv0 == offset_readback_o[0] *
    (pwm_mode_setting_i[0][2] ? 11'sh00A : 11'sh005))
    else $error("offset step wrong");
  chk_nom_offset: assert property (
    (run_ok && $stable(mv0) && $stable(nominal_vout_target_i[0]))[*3] |->
    nominal_adj_o[0] == addo(nominal_vout_target_i[0], mv0))
    else $error("nominal target not offset");
  chk_servo_path: assert property (
    (run_ok && $stable(mv0) && $stable(servo_en_i[0]) &&
     margin_sel_i[0] == 2'h1)[*3] |-> servo_target_o[0] == (servo_en_i[0] ?
     addo(margin_high_i[0], mv0) : margin_high_i[0]))
    else $error("servo target wrong");
  chk_fault_shift: assert property (
    (run_ok && $stable(mv0) && $stable(pwm_mode_setting_i[0]))[*3] |->
    ov_fault_adj_o[0] == (pwm_mode_setting_i[0][3] ?
    addo(ov_fault_i[0], mv0) : ov_fault_i[0]))
    else $error("fault limit wrong");
  chk_warn_fixed: assert property (
    run_ok |-> ov_warn_o == $past(ov_warn_i))
    else $error("warn limit moved");
  chk_rail_clear: assert property (
    rail_off_i[0] [*3] |-> offset_readback_o[0] == 6'sh00 && mv0 == 11'sh000)
    else $error("rail off kept offset");
  chk_cmd_clear: assert property (
    (device_reset_cmd_i || restore_cmd_i)[*3] |-> offset_readback_o == '0)
    else $error("command kept offset");
  cover property ($rose(xfer_error_flag_oe_o));
  cover property ($changed(offset_readback_o[1]));
  cover property (pwm_mode_setting_i[1][4] && $changed(offset_readback_o[0]));
endmodule
bind svo_top svo_top_properties #(.VW(VW)) svo_top_properties_inst (
  .clk_i, .srst_i, .chip_select_n_i, .xfer_error_flag_o,
  .xfer_error_flag_oe_o, .pwm_mode_setting_i, .rail_off_i,
  .device_reset_cmd_i, .restore_cmd_i, .servo_en_i, .margin_sel_i,
  .nominal_vout_target_i, .margin_high_i, .ov_fault_i, .ov_warn_i,
  .nominal_adj_o, .servo_target_o, .ov_fault_adj_o, .ov_warn_o,
  .offset_readback_o, .offset_mv_o);

// File: testbench/svo_spi_host.sv
// Purpose: serial host model sending offset packets
// Assumes: mode 1, 8 MHz serial clock
// Notes: data line shows the inverse of its last bit when deselected
`timescale 1ns/100ps
module svo_spi_host (
  input wire logic clk_i,
  output logic sck_o,
  output logic csn_o,
  output logic sdi_o
);
  initial begin
    sck_o = 1'b0;
    csn_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic xfer(input logic [7:0] p, input int n, input int gap);
    csn_o = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      sck_o = 1'b1;
      sdi_o = (i < 8) ? p[7 - i] : 1'b0;
      #62.5;
      sck_o = 1'b0;
      #62.5;
    end
    #50;
    csn_o = 1'b1;
    sdi_o = ~sdi_o;
    #gap;
    @(negedge clk_i);
  endtask
endmodule

// File: testbench/svo_top_tb_top.sv
// Purpose: self-checking bench of the serial offset receiver
// Assumes: apply gap set to 10 us, host spaces packets 10.5 us
// Notes: expected offsets tracked in e, two's complement
`timescale 1ns/100ps
module svo_top_tb_top;
  import svo_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  wire logic sck_i, chip_select_n_i, sdi_i;
  logic [1:0][7:0] pwm_mode_setting_i = '0;
  logic [1:0] rail_off_i = '0, servo_en_i = '0;
  logic device_reset_cmd_i = 1'b0, restore_cmd_i = 1'b0;
  logic [1:0][1:0] margin_sel_i = {2'h0, 2'h1};
  logic [1:0][15:0] nominal_vout_target_i = {16'h0800, 16'h0400};
  logic [1:0][15:0] margin_high_i = {16'h0900, 16'h0500};
  logic [1:0][15:0] margin_low_i = {16'h0700, 16'h0300};
  logic [1:0][15:0] ov_fault_i = {16'h0A00, 16'h0600};
  logic [1:0][15:0] uv_fault_i = {16'h0600, 16'h0200};
  logic [1:0][15:0] ov_warn_i = {16'h0980, 16'h0580};
  logic [1:0][15:0] uv_warn_i = {16'h0680, 16'h0280};
  logic xfer_error_flag_o, xfer_error_flag_oe_o;
  logic [1:0][15:0] nominal_adj_o, margin_high_adj_o, margin_low_adj_o;
  logic [1:0][15:0] servo_target_o, ov_fault_adj_o, uv_fault_adj_o;
  logic [1:0][15:0] ov_warn_o, uv_warn_o;
  svo_code_type [1:0] offset_readback_o;
  svo_mv_type [1:0] offset_mv_o;
  svo_code_type e [2] = '{6'sh00, 6'sh00};
  logic [4:0] mags [4] = '{5'h1F, 5'h1F, 5'h01, 5'h11};
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  initial forever #5 clk_i = ~clk_i;
  svo_top #(.GAP_CYC(1000)) svo_top_inst (.clk_i, .srst_i, .sck_i,
    .chip_select_n_i, .sdi_i, .xfer_error_flag_o, .xfer_error_flag_oe_o,
    .pwm_mode_setting_i, .rail_off_i, .device_reset_cmd_i, .restore_cmd_i,
    .servo_en_i, .margin_sel_i, .nominal_vout_target_i, .margin_high_i,
    .margin_low_i, .ov_fault_i, .uv_fault_i, .ov_warn_i, .uv_warn_i,
    .nominal_adj_o, .margin_high_adj_o, .margin_low_adj_o, .servo_target_o,
    .ov_fault_adj_o, .uv_fault_adj_o, .ov_warn_o, .uv_warn_o,
    .offset_readback_o, .offset_mv_o);
  svo_spi_host svo_spi_host_inst (.clk_i(clk_i), .sck_o(sck_i),
    .csn_o(chip_select_n_i), .sdi_o(sdi_i));
  // ****************
  // helpers
  // ****************
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] mk(input logic [6:0] b);
    return {b, ~^b};
  endfunction
  function automatic svo_mv_type mvf(input int k);
    return svo_mv_type'(e[k]) *
      (pwm_mode_setting_i[k][2] ? 11'sh00A : 11'sh005);
  endfunction
  task put(input logic [7:0] p);
    svo_code_type c;
    c = p[6] ? -svo_code_type'({1'b0, p[5:1]}) :
      svo_code_type'({1'b0, p[5:1]});
    svo_spi_host_inst.xfer(p, 8, 10500);
    // broadcast reaches both channels whatever the channel bit
    if (pwm_mode_setting_i[0][4] | pwm_mode_setting_i[1][4]) e = '{c, c};
    else e[p[7]] = c;
  endtask
  task verify;
    @(negedge clk_i);
    for (int k = 0; k < 2; k++) begin
      chk(16'(offset_readback_o[k]), 16'(e[k]));
      chk(16'(offset_mv_o[k]), 16'(mvf(k)));
      chk(nominal_adj_o[k], nominal_vout_target_i[k] + 16'(mvf(k)));
      chk(margin_high_adj_o[k], margin_high_i[k] + 16'(mvf(k)));
      chk(margin_low_adj_o[k], margin_low_i[k] + 16'(mvf(k)));
    end
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      finish_test();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    logic [15:0] d;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    verify();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      pwm_mode_setting_i[i % 2][2] <= i[1] ^ i[0];
      put(mk({i[0], i[1], mags[i]}));
      verify();
    end
    for (int i = 0; i < 3; i++) begin
      svo_spi_host_inst.xfer(mk(7'h45) ^ 8'(i == 0), i ? 5 + 2 * i : 8, 10500);
      chk(16'(xfer_error_flag_oe_o), 16'h0001);
      verify();
    end
    put(mk(7'h23));
    chk(16'(xfer_error_flag_oe_o), 16'h0000);
    @(posedge clk_i);
    pwm_mode_setting_i[1][4] <= 1'b1;
    put(mk(7'h2B));
    verify();
    @(posedge clk_i);
    pwm_mode_setting_i[1][4] <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      servo_en_i[0] <= !i[0];
      pwm_mode_setting_i[0][3] <= !i[0];
      margin_sel_i[0] <= i ? 2'h2 : 2'h1;
      d = i ? 16'h0000 : 16'(mvf(0));
      repeat (4) @(negedge clk_i);
      chk(servo_target_o[0],
        (i ? margin_low_i[0] : margin_high_i[0]) + d);
      chk(ov_fault_adj_o[0], ov_fault_i[0] + d);
      chk(uv_fault_adj_o[0], uv_fault_i[0] + d);
      chk(ov_warn_o[0], ov_warn_i[0]);
      chk(uv_warn_o[0], uv_warn_i[0]);
      @(posedge clk_i);
    end
    for (int i = 0; i < 3; i++) begin
      put(mk(7'h07));
      put(mk(7'h48));
      @(posedge clk_i);
      rail_off_i[0] <= (i == 0);
      device_reset_cmd_i <= (i == 1);
      restore_cmd_i <= (i == 2);
      repeat (4) @(posedge clk_i);
      rail_off_i <= '0;
      device_reset_cmd_i <= 1'b0;
      restore_cmd_i <= 1'b0;
      e[0] = 6'sh00;
      if (i != 0) e[1] = 6'sh00;
      verify();
    end
    // packets faster than the apply rate pile up until the buffer refuses
    for (int i = 0; i < 20; i++) svo_spi_host_inst.xfer(mk(7'h0E), 8, 200);
    chk(16'(xfer_error_flag_oe_o), 16'h0001);
    repeat (20000) @(posedge clk_i);
    e[0] = 6'sh0E;
    verify();
    finish_test();
  end
endmodule
